// ---- rtl/tmw_consts.svh ----
// Constants for the eight-bit waveform timer: register offsets, field positions, codes and prescaler masks.
// Assumes inclusion by bare name from the timer package and the timer module.
`ifndef TMW_CONSTS_SVH
`define TMW_CONSTS_SVH
// ----------------------------------------------------------------------------
// Register byte offsets (low address byte only).
// ----------------------------------------------------------------------------
`define TMW_OFF_CTRL_A 8'h00
`define TMW_OFF_CTRL_B 8'h04
`define TMW_OFF_COUNT 8'h08
`define TMW_OFF_CMP_A 8'h0C
`define TMW_OFF_CMP_B 8'h10
`define TMW_OFF_FLAGS 8'h14
// ----------------------------------------------------------------------------
// Field positions and values.
// ----------------------------------------------------------------------------
`define TMW_A_OMA 7:6
`define TMW_A_OMB 5:4
`define TMW_A_WM 1:0
`define TMW_B_WMHI 3
`define TMW_B_CS 2:0
`define TMW_F_OVF 0
`define TMW_F_MA 1
`define TMW_F_MB 2
`define TMW_BOTTOM 8'h00
`define TMW_MAX 8'hFF
`define TMW_ONE 8'h01
`define TMW_RST8 8'h00
// Waveform mode codes.
`define TMW_WM_NORMAL 3'h0
`define TMW_WM_PC_FF 3'h1
`define TMW_WM_CTC 3'h2
`define TMW_WM_FAST_FF 3'h3
`define TMW_WM_PC_OCR 3'h5
`define TMW_WM_FAST_OCR 3'h7
// Output mode codes.
`define TMW_OM_TOGGLE 2'h1
`define TMW_OM_CLEAR 2'h2
`define TMW_OM_SET 2'h3
// Clock select codes and prescaler masks for 1, 8, 64, 256, 1024.
`define TMW_CS_DIV1 3'h1
`define TMW_CS_DIV8 3'h2
`define TMW_CS_DIV64 3'h3
`define TMW_CS_DIV256 3'h4
`define TMW_CS_DIV1024 3'h5
`define TMW_MASK_DIV8 10'h007
`define TMW_MASK_DIV64 10'h03F
`define TMW_MASK_DIV256 10'h0FF
`define TMW_MASK_DIV1024 10'h3FF
`endif

// ---- rtl/tmw_pkg.sv ----
// Types shared by the eight-bit waveform timer.
// Assumes the constants header sits beside it.
package tmw_pkg;
  `include "tmw_consts.svh"
  // Counting family selected by the waveform mode, one-hot.
  typedef enum logic [3:0] {
    tmw_cls_normal = 4'b0001,
    tmw_cls_phase = 4'b0010,
    tmw_cls_ctc = 4'b0100,
    tmw_cls_fast = 4'b1000
  } tmw_class_t;
endpackage : tmw_pkg

// ---- rtl/tmw_timer.sv ----
// Eight-bit timer/counter with normal, clear-on-match, fast PWM and phase-correct PWM waveforms.
// Assumes a single AHB-Lite master, one clock hclk and inputs synchronous to it.
//
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "tmw_consts.svh"

// Summary of operation
// RQ1 - Normal mode counts up, wraps FF to 00.
// RQ2 - Normal mode sets overflow when count becomes zero.
// RQ3 - Clear-on-match clears count at compare A.
// RQ4 - Clear-on-match sets match A at top.
// RQ5 - Clear-on-match compare unbuffered; missed match wraps.
// RQ6 - Clear-on-match toggle mode inverts output A.
// RQ7 - Clear-on-match sets overflow on FF-to-00 wrap.
// RQ8 - Fast PWM tops: FF (mode 3), A (7).
// RQ9 - Fast PWM returns to bottom after top.
// RQ10 - Fast PWM sets overflow at top.
// RQ11 - Fast PWM clear/set at match and bottom.
// RQ12 - Fast PWM toggles A only, with high bit.
// RQ13 - Fast PWM extremes give spike or constant level.
// RQ14 - Fast PWM toggle like clear-on-match, buffered compare.
// RQ15 - Phase PWM modes 1 and 5, dual slope.
// RQ16 - Phase PWM reverses at top, holds one tick.
// RQ17 - Phase PWM sets overflow at bottom.
// RQ18 - Phase PWM clears up-match, sets down-match.
// RQ19 - Phase PWM toggles A only, with high bit.
// RQ20 - Phase PWM extremes give constant levels.
// RQ21 - Phase PWM output restored at bottom for symmetry.
// RQ22 - Timer tick from prescale 1,8,64,256,1024.
// RQ23 - Software count write beats clear or count.
// RQ24 - Match flag set on tick after equality.
// RQ25 - Count write blocks matches for one tick.
// RQ26 - PWM compare writes buffered, loaded at top/bottom.
// RQ27 - Count and compares are 8-bit readable registers.
module tmw_timer #(
  parameter int PRESC_W = 10
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic wave_out_a,
  output logic wave_out_a_en,
  output logic wave_out_b,
  output logic wave_out_b_en
);
  // ----------------------------------------------------------------------------
  // State declarations.
  // ----------------------------------------------------------------------------
  logic [1:0] output_a_mode; // Channel A output mode.
  logic [1:0] output_b_mode; // Channel B output mode.
  logic [1:0] wm_lo_q; // Low waveform mode bits.
  logic waveform_mode_high_bit; // High waveform mode bit.
  logic [2:0] cs_q; // Clock select.
  logic [7:0] count_value; // The counter.
  logic [7:0] buf_a_q, buf_b_q; // Software-side compare values.
  logic [7:0] compare_a_value, compare_b_value; // Active compare values.
  logic up_q; // Phase-correct direction, high while counting up.
  logic blk_q; // Match block armed by a count write.
  logic overflow_flag, match_a_flag, match_b_flag; // Sticky event flags.
  logic wa_q, wb_q; // Output compare states.
  logic [PRESC_W-1:0] presc_q; // Free-running prescaler.
  logic dwr_q; // Write data phase pending.
  logic [7:0] daddr_q; // Address of the pending data phase.
  logic [31:0] rdata_q; // Registered read data.
  logic [7:0] cnt_d;
  logic up_d;
  logic ovf_ev;
  // ----------------------------------------------------------------------------
  // Decode of mode, top and events.
  // ----------------------------------------------------------------------------
  logic [2:0] wms;
  tmw_pkg::tmw_class_t cls;
  logic pwm, tick, at_top, m_a, m_b, top_ev, bot_ev, upd, a_top, b_top;
  logic [7:0] top;
  logic [PRESC_W-1:0] mask;
  logic cnt_wr, flag_wr, upd_ok;
  logic [7:0] wd;

  assign wms = {waveform_mode_high_bit, wm_lo_q};
  assign wd = hwdata[7:0];
  assign cnt_wr = dwr_q && (daddr_q == `TMW_OFF_COUNT);
  assign flag_wr = dwr_q && (daddr_q == `TMW_OFF_FLAGS);

  // Mode family; the two unlisted codes behave as normal counting.
  always_comb begin
    case (wms)
      `TMW_WM_PC_FF, `TMW_WM_PC_OCR: cls = tmw_pkg::tmw_cls_phase; // [RQ15]
      `TMW_WM_CTC: cls = tmw_pkg::tmw_cls_ctc;
      `TMW_WM_FAST_FF, `TMW_WM_FAST_OCR: cls = tmw_pkg::tmw_cls_fast; // [RQ8]
      default: cls = tmw_pkg::tmw_cls_normal;
    endcase
  end

  assign pwm = (cls == tmw_pkg::tmw_cls_phase) || (cls == tmw_pkg::tmw_cls_fast);
  // Top is compare A in modes 5 and 7, otherwise the full count.
  assign top = (wms == `TMW_WM_PC_OCR || wms == `TMW_WM_FAST_OCR) ? compare_a_value : `TMW_MAX; // [RQ8] [RQ15]
  assign at_top = (count_value == top);

  // Prescaler tick; a stopped selection gives no tick at all.
  always_comb begin
    case (cs_q)
      `TMW_CS_DIV8: mask = `TMW_MASK_DIV8;
      `TMW_CS_DIV64: mask = `TMW_MASK_DIV64;
      `TMW_CS_DIV256: mask = `TMW_MASK_DIV256;
      `TMW_CS_DIV1024: mask = `TMW_MASK_DIV1024;
      default: mask = '0;
    endcase
  end
  assign tick = (cs_q == `TMW_CS_DIV1) || ((cs_q >= `TMW_CS_DIV8) && (cs_q <= `TMW_CS_DIV1024) &&
                ((presc_q & mask) == mask)); // [RQ22]

  // Equality seen during a tick period is acted on at the closing tick.
  assign m_a = tick && !blk_q && (count_value == compare_a_value); // [RQ24] [RQ25]
  assign m_b = tick && !blk_q && (count_value == compare_b_value); // [RQ24] [RQ25]
  assign top_ev = tick && at_top;
  assign bot_ev = tick && !up_q && (count_value == `TMW_BOTTOM);
  assign upd_ok = (cls == tmw_pkg::tmw_cls_fast) || up_q;
  // Buffered compares load at top, as the count turns to bottom or down.
  assign upd = tick && pwm && upd_ok && (at_top || count_value == `TMW_MAX); // [RQ26]
  assign a_top = (compare_a_value == top);
  assign b_top = (compare_b_value == top);

  // ----------------------------------------------------------------------------
  // Counter sequencing.
  // ----------------------------------------------------------------------------
  // Next count, direction and overflow event for each mode family.
  always_comb begin
    cnt_d = count_value;
    up_d = (cls == tmw_pkg::tmw_cls_phase) ? up_q : 1'b1;
    ovf_ev = 1'b0;
    if (tick) begin
      case (cls)
        tmw_pkg::tmw_cls_normal: begin
          cnt_d = count_value + `TMW_ONE; // [RQ1]
          ovf_ev = (count_value == `TMW_MAX); // [RQ2]
        end
        tmw_pkg::tmw_cls_ctc: begin
          // A compare written below the count is passed by; the count wraps first.
          cnt_d = (count_value == compare_a_value) ? `TMW_BOTTOM : count_value + `TMW_ONE; // [RQ3] [RQ5]
          ovf_ev = (count_value == `TMW_MAX); // [RQ7]
        end
        tmw_pkg::tmw_cls_fast: begin
          cnt_d = at_top ? `TMW_BOTTOM : count_value + `TMW_ONE; // [RQ9]
          ovf_ev = at_top; // [RQ10]
        end
        tmw_pkg::tmw_cls_phase: begin
          if (up_q) begin
            // Top was held for this one tick; turn round now.
            if (at_top || count_value == `TMW_MAX) begin
              up_d = (count_value == `TMW_BOTTOM); // [RQ16]
              cnt_d = (count_value == `TMW_BOTTOM) ? `TMW_BOTTOM : count_value - `TMW_ONE;
              ovf_ev = (count_value == `TMW_BOTTOM);
            end else begin
              cnt_d = count_value + `TMW_ONE;
            end
          end else if (count_value == `TMW_BOTTOM) begin
            up_d = 1'b1;
            cnt_d = (top == `TMW_BOTTOM) ? `TMW_BOTTOM : `TMW_ONE;
          end else begin
            cnt_d = count_value - `TMW_ONE;
            ovf_ev = (count_value == `TMW_ONE); // [RQ17]
          end
        end
        default: cnt_d = count_value;
      endcase
    end
    // Software write wins over every clear and count.
    if (cnt_wr) begin
      cnt_d = wd; // [RQ23]
    end
  end

  // Counter and direction registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_value <= `TMW_RST8;
      up_q <= 1'b1;
    end else begin
      count_value <= cnt_d;
      up_q <= up_d;
    end
  end

  // Prescaler runs freely; it has no reset dependency beyond a zero start.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + {{(PRESC_W-1){1'b0}}, 1'b1};
    end
  end

  // Match block: armed by a count write, spent by the next tick, even if stopped meanwhile.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blk_q <= 1'b0;
    end else if (cnt_wr) begin
      blk_q <= 1'b1; // [RQ25]
    end else if (tick) begin
      blk_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Flags, set wins over a write-one clear.
  // ----------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_flag <= 1'b0;
      match_a_flag <= 1'b0;
      match_b_flag <= 1'b0;
    end else begin
      overflow_flag <= ovf_ev || (overflow_flag && !(flag_wr && wd[`TMW_F_OVF])); // [RQ2] [RQ7]
      match_a_flag <= m_a || (match_a_flag && !(flag_wr && wd[`TMW_F_MA])); // [RQ4] [RQ24]
      match_b_flag <= m_b || (match_b_flag && !(flag_wr && wd[`TMW_F_MB])); // [RQ24]
    end
  end

  // ----------------------------------------------------------------------------
  // Compare registers; direct in non-PWM modes, buffered in PWM modes.
  // ----------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buf_a_q <= `TMW_RST8;
      buf_b_q <= `TMW_RST8;
      compare_a_value <= `TMW_RST8;
      compare_b_value <= `TMW_RST8;
    end else begin
      if (dwr_q && daddr_q == `TMW_OFF_CMP_A) begin
        buf_a_q <= wd; // [RQ27]
      end
      if (dwr_q && daddr_q == `TMW_OFF_CMP_B) begin
        buf_b_q <= wd;
      end
      if (!pwm && dwr_q && daddr_q == `TMW_OFF_CMP_A) begin
        compare_a_value <= wd; // [RQ5]
      end else if (!pwm || upd) begin
        compare_a_value <= buf_a_q; // [RQ26] [RQ14]
      end
      if (!pwm && dwr_q && daddr_q == `TMW_OFF_CMP_B) begin
        compare_b_value <= wd;
      end else if (!pwm || upd) begin
        compare_b_value <= buf_b_q; // [RQ26]
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Waveform generation.
  // ----------------------------------------------------------------------------
  // Next output state for one channel; tog_ok is false for channel B.
  function automatic logic wave_next(input logic cur, input logic [1:0] om, input tmw_pkg::tmw_class_t c,
                                     input logic match, input logic tog_ok, input logic ocr_top,
                                     input logic tev, input logic bev, input logic up_after);
    logic n;
    n = cur;
    case (c)
      tmw_pkg::tmw_cls_normal, tmw_pkg::tmw_cls_ctc: begin
        if (match && om == `TMW_OM_TOGGLE) begin
          n = !cur; // [RQ6]
        end else if (match && om[1]) begin
          n = om[0];
        end
      end
      tmw_pkg::tmw_cls_fast: begin
        if (om == `TMW_OM_TOGGLE) begin
          n = (tog_ok && match) ? !cur : cur; // [RQ12] [RQ14]
        end else if (om[1] && tev) begin
          n = !om[0]; // [RQ11] [RQ13]
        end else if (om[1] && match && !ocr_top) begin
          n = om[0]; // [RQ11]
        end
      end
      tmw_pkg::tmw_cls_phase: begin
        if (om == `TMW_OM_TOGGLE) begin
          n = (tog_ok && match) ? !cur : cur; // [RQ19]
        end else if (om[1] && ocr_top && tev) begin
          n = !om[0]; // [RQ20]
        end else if (om[1] && match && !ocr_top) begin
          n = up_after ? om[0] : !om[0]; // [RQ18] [RQ20]
        end else if (om[1] && bev) begin
          n = !om[0]; // [RQ21]
        end
      end
      default: n = cur;
    endcase
    return n;
  endfunction : wave_next

  // Output compare states; they survive mode changes and start low.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wa_q <= 1'b0;
      wb_q <= 1'b0;
    end else begin
      wa_q <= wave_next(wa_q, output_a_mode, cls, m_a, waveform_mode_high_bit, a_top, top_ev, bot_ev, up_d);
      wb_q <= wave_next(wb_q, output_b_mode, cls, m_b, 1'b0, b_top, top_ev, bot_ev, up_d);
    end
  end

  assign wave_out_a = wa_q;
  assign wave_out_b = wb_q;
  // The pin is taken over whenever a channel output mode is non-zero.
  assign wave_out_a_en = |output_a_mode;
  assign wave_out_b_en = |output_b_mode;

  // ----------------------------------------------------------------------------
  // AHB-Lite slave, zero wait states, always OKAY.
  // ----------------------------------------------------------------------------
  // Address phase capture; read data is sampled here so hrdata is a flop output.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dwr_q <= 1'b0;
      daddr_q <= `TMW_RST8;
      rdata_q <= '0;
    end else begin
      dwr_q <= hsel && hready && htrans[1] && hwrite;
      daddr_q <= haddr[7:0];
      rdata_q <= '0;
      if (hsel && hready && htrans[1] && !hwrite) begin
        case (haddr[7:0])
          `TMW_OFF_CTRL_A: rdata_q <= {24'h000000, output_a_mode, output_b_mode, 2'h0, wm_lo_q};
          `TMW_OFF_CTRL_B: rdata_q <= {28'h0000000, waveform_mode_high_bit, cs_q};
          `TMW_OFF_COUNT: rdata_q <= {24'h000000, count_value}; // [RQ27]
          `TMW_OFF_CMP_A: rdata_q <= {24'h000000, buf_a_q};
          `TMW_OFF_CMP_B: rdata_q <= {24'h000000, buf_b_q};
          `TMW_OFF_FLAGS: rdata_q <= {29'h00000000, match_b_flag, match_a_flag, overflow_flag};
          default: rdata_q <= '0;
        endcase
      end
    end
  end

  // Control registers; writes land at the end of the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      output_a_mode <= 2'h0;
      output_b_mode <= 2'h0;
      wm_lo_q <= 2'h0;
      waveform_mode_high_bit <= 1'b0;
      cs_q <= 3'h0;
    end else if (dwr_q && daddr_q == `TMW_OFF_CTRL_A) begin
      output_a_mode <= wd[`TMW_A_OMA];
      output_b_mode <= wd[`TMW_A_OMB];
      wm_lo_q <= wd[`TMW_A_WM];
    end else if (dwr_q && daddr_q == `TMW_OFF_CTRL_B) begin
      waveform_mode_high_bit <= wd[`TMW_B_WMHI];
      cs_q <= wd[`TMW_B_CS];
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------------------
  // Assertions and covers.
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_NORMAL_WRAP: assert property (tick && cls == tmw_pkg::tmw_cls_normal && count_value == `TMW_MAX && // [RQ1]
    !cnt_wr |=> count_value == `TMW_BOTTOM)
    else $error("normal mode did not wrap to zero");
  // The flag is set even when a count write lands at the wrap; only the count then differs.
  AST_NORMAL_OVF: assert property (tick && cls == tmw_pkg::tmw_cls_normal && count_value == `TMW_MAX // [RQ2]
    |=> overflow_flag && (count_value == `TMW_BOTTOM || $past(cnt_wr))) else $error("overflow not set at zero");
  AST_CTC_CLEAR: assert property (tick && cls == tmw_pkg::tmw_cls_ctc && count_value == compare_a_value && // [RQ3]
    !cnt_wr |=> count_value == `TMW_BOTTOM)
    else $error("clear-on-match did not clear");
  AST_MATCH_A: assert property (tick && !blk_q && count_value == compare_a_value // [RQ4]
    |=> match_a_flag) else $error("match A flag not set");
  AST_CTC_TOGGLE: assert property (m_a && cls == tmw_pkg::tmw_cls_ctc && output_a_mode == `TMW_OM_TOGGLE // [RQ6]
    |=> wave_out_a != $past(wave_out_a)) else $error("output A did not toggle");
  AST_FAST_RESTART: assert property (tick && cls == tmw_pkg::tmw_cls_fast && at_top && !cnt_wr // [RQ9]
    |=> count_value == `TMW_BOTTOM && overflow_flag) else $error("fast PWM did not restart");
  AST_PC_TURN: assert property (tick && cls == tmw_pkg::tmw_cls_phase && up_q && at_top && // [RQ16]
    top != `TMW_BOTTOM && !cnt_wr |=> !up_q && count_value == $past(count_value) - `TMW_ONE)
    else $error("phase PWM did not turn at top");
  AST_PC_OVF: assert property (tick && cls == tmw_pkg::tmw_cls_phase && !up_q && count_value == `TMW_ONE // [RQ17]
    |=> overflow_flag) else $error("overflow not set at bottom");
  AST_CNT_WRITE: assert property (cnt_wr |=> count_value == $past(wd)) else $error("count write lost"); // [RQ23]
  AST_BLOCK: assert property (blk_q && tick && !match_a_flag && !cnt_wr // [RQ25]
    |=> !match_a_flag) else $error("match not blocked after count write");
  AST_DIV8: assert property (cs_q == `TMW_CS_DIV8 && tick |-> presc_q[2:0] == 3'h7) // [RQ22]
    else $error("divide-by-8 tick misplaced");

  // Covers for the main scenarios, including a match suppressed by a count write.
  COV_CTC_MATCH: cover property (cls == tmw_pkg::tmw_cls_ctc && m_a);
  COV_BLOCKED: cover property (blk_q && tick && count_value == compare_a_value);
  COV_FAST_TOP: cover property (cls == tmw_pkg::tmw_cls_fast && top_ev);
  COV_PC_BOTTOM: cover property (cls == tmw_pkg::tmw_cls_phase && bot_ev);
endmodule : tmw_timer

// ---- tb/tmw_testbench.sv ----
// Self-checking bench for the eight-bit waveform timer: a table of mode cases, then register and reset tests.
// Assumes the timer is the only AHB-Lite slave, so its hreadyout feeds the bus hready.
`timescale 1ns/100ps
`include "tmw_consts.svh"
module testbench;
  // --------------------------------------------------------------------------
  // Case table type and bus signals.
  // --------------------------------------------------------------------------
  // One case: control A, high mode bit, compare A, start count, clock select, window length,
  // then bounds on high cycles and toggles of output A, a flag mask with its value, and count bounds.
  typedef struct packed {logic [7:0] ca; logic wh; logic [7:0] cp, cn; logic [2:0] cs; int n, hl, hh, tl, th;
    logic [7:0] fm, fe, cl, ch;} tmw_row_t;
  localparam int AN = 99999; // Upper bound for figures a case does not judge.
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, rdv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hrdata;
  logic hreadyout, hresp, woa, woa_en, wob, wob_en;
  wire logic hready = hreadyout; // Single slave, so its ready is the bus ready.
  int err_count = 0, compares = 0, hi_cnt = 0, tog_cnt = 0, h0, t0;
  logic prev_a = 1'b0;
  tmw_row_t rows [24] = '{
    '{8'h00, 1'b0, 8'h80, 8'hFE, 3'h1, 4, 0, AN, 0, AN, 8'h05, 8'h05, 8'h01, 8'h10},
    '{8'h42, 1'b0, 8'h03, 8'h00, 3'h1, 40, 0, AN, 9, 11, 8'h03, 8'h02, 8'h00, 8'h03},
    '{8'h42, 1'b0, 8'h00, 8'h00, 3'h1, 20, 0, AN, 19, 21, 8'h03, 8'h02, 8'h00, 8'h00},
    '{8'h02, 1'b0, 8'h05, 8'h10, 3'h1, 20, 0, AN, 0, AN, 8'h03, 8'h00, 8'h30, 8'h3F},
    '{8'h02, 1'b0, 8'h05, 8'hFD, 3'h1, 2, 0, AN, 0, AN, 8'h01, 8'h01, 8'h01, 8'h06},
    '{8'h00, 1'b0, 8'h10, 8'h10, 3'h1, 2, 0, AN, 0, AN, 8'h02, 8'h00, 8'h11, 8'h18},
    '{8'h00, 1'b0, 8'h10, 8'h0F, 3'h1, 2, 0, AN, 0, AN, 8'h02, 8'h02, 8'h10, 8'h18},
    '{8'h83, 1'b0, 8'h40, 8'h00, 3'h1, 512, 127, 133, 0, AN, 8'h01, 8'h01, 8'h00, 8'hFF},
    '{8'hC3, 1'b0, 8'h40, 8'h00, 3'h1, 512, 379, 385, 0, AN, 8'h01, 8'h01, 8'h00, 8'hFF},
    '{8'h83, 1'b0, 8'hFF, 8'h00, 3'h1, 512, 511, 512, 0, AN, 8'h01, 8'h01, 8'h00, 8'hFF},
    '{8'h83, 1'b0, 8'h00, 8'h00, 3'h1, 512, 1, 3, 0, AN, 8'h01, 8'h01, 8'h00, 8'hFF},
    '{8'h43, 1'b1, 8'h03, 8'h00, 3'h1, 40, 0, AN, 9, 11, 8'h03, 8'h03, 8'h00, 8'h03},
    '{8'h43, 1'b0, 8'h03, 8'h00, 3'h1, 40, 0, AN, 0, 0, 8'h01, 8'h00, 8'h00, 8'hFF},
    '{8'h81, 1'b0, 8'h40, 8'h00, 3'h1, 510, 125, 131, 0, AN, 8'h01, 8'h01, 8'h00, 8'hFF},
    '{8'hC1, 1'b0, 8'h40, 8'h00, 3'h1, 510, 379, 385, 0, AN, 8'h01, 8'h01, 8'h00, 8'hFF},
    '{8'h81, 1'b0, 8'h00, 8'h00, 3'h1, 510, 0, 0, 0, AN, 8'h01, 8'h01, 8'h00, 8'hFF},
    '{8'h81, 1'b0, 8'hFF, 8'h00, 3'h1, 510, 508, 510, 0, AN, 8'h01, 8'h01, 8'h00, 8'hFF},
    '{8'h41, 1'b1, 8'h03, 8'h00, 3'h1, 60, 0, AN, 9, 11, 8'h01, 8'h01, 8'h00, 8'h03},
    '{8'h00, 1'b0, 8'hFF, 8'h00, 3'h1, 100, 0, AN, 0, AN, 8'h01, 8'h00, 8'hC7, 8'hD0},
    '{8'h00, 1'b0, 8'hFF, 8'h00, 3'h2, 100, 0, AN, 0, AN, 8'h01, 8'h00, 8'h17, 8'h1B},
    '{8'h00, 1'b0, 8'hFF, 8'h00, 3'h3, 100, 0, AN, 0, AN, 8'h01, 8'h00, 8'h02, 8'h04},
    '{8'h00, 1'b0, 8'hFF, 8'h00, 3'h4, 600, 0, AN, 0, AN, 8'h01, 8'h00, 8'h03, 8'h05},
    '{8'h00, 1'b0, 8'hFF, 8'h00, 3'h5, 2100, 0, AN, 0, AN, 8'h01, 8'h00, 8'h03, 8'h05},
    '{8'h00, 1'b0, 8'hFF, 8'h22, 3'h0, 10, 0, AN, 0, AN, 8'h07, 8'h00, 8'h22, 8'h22}};
  logic [7:0] offs [6] = '{`TMW_OFF_CTRL_A, `TMW_OFF_CTRL_B, `TMW_OFF_COUNT, `TMW_OFF_CMP_A, `TMW_OFF_CMP_B,
    `TMW_OFF_FLAGS};

  tmw_timer #(.PRESC_W(10)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .wave_out_a(woa), .wave_out_a_en(woa_en), .wave_out_b(wob), .wave_out_b_en(wob_en));

  // --------------------------------------------------------------------------
  // Clock, output monitor and shared tasks.
  // --------------------------------------------------------------------------
  // A 40 ns period gives the 25 MHz bus clock.
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // Counts high cycles and level changes of output A; cases take differences, so no one resets these.
  always @(posedge hclk) begin
    if (woa === 1'b1) hi_cnt <= hi_cnt + 1;
    if (woa !== prev_a) tog_cnt <= tog_cnt + 1;
    prev_a <= woa;
  end
  // Compares one value and counts the comparison.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Range check; an unknown value makes the test unknown and so fails.
  task automatic inr(input string nm, input logic [31:0] v, input int lo, input int hi);
    chk(nm, {31'h0, (v >= lo && v <= hi)}, 32'h1);
  endtask : inr
  // One single AHB-Lite transfer; read data is taken at the edge that ends the data phase.
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask : xfer
  // Sets up one case with the timer stopped, runs a warm-up window, measures a second window, then stops.
  task automatic run_row(input tmw_row_t r);
    xfer(`TMW_OFF_CTRL_B, 1'b1, 8'h00);
    xfer(`TMW_OFF_CTRL_A, 1'b1, 8'h00); // Normal mode first, so the compare write lands at once.
    xfer(`TMW_OFF_CMP_A, 1'b1, r.cp);
    xfer(`TMW_OFF_COUNT, 1'b1, r.cn);
    xfer(`TMW_OFF_CTRL_A, 1'b1, r.ca);
    xfer(`TMW_OFF_FLAGS, 1'b1, 8'h07);
    xfer(`TMW_OFF_CTRL_B, 1'b1, {4'h0, r.wh, r.cs});
    repeat (r.n) @(posedge hclk);
    h0 = hi_cnt;
    t0 = tog_cnt;
    repeat (r.n) @(posedge hclk);
    inr("high cycles", hi_cnt - h0, r.hl, r.hh);
    inr("toggles", tog_cnt - t0, r.tl, r.th);
    xfer(`TMW_OFF_CTRL_B, 1'b1, {4'h0, r.wh, 3'h0});
    xfer(`TMW_OFF_FLAGS, 1'b0, 8'h00);
    chk("flags", rdv & {24'h0, r.fm}, {24'h0, r.fe});
    xfer(`TMW_OFF_COUNT, 1'b0, 8'h00);
    inr("count", rdv, r.cl, r.ch);
  endtask : run_row
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // --------------------------------------------------------------------------
  // Main sequence and watchdog.
  // --------------------------------------------------------------------------
  // The table loop runs first; register access and a mid-run reset follow by hand.
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    foreach (rows[i]) run_row(rows[i]);
    xfer(`TMW_OFF_CTRL_A, 1'b1, 8'hFF);
    xfer(`TMW_OFF_CTRL_A, 1'b0, 8'h00);
    chk("control a", rdv, 32'hF3);
    chk("enable a", {31'h0, woa_en}, 32'h1);
    chk("enable b", {31'h0, wob_en}, 32'h1);
    xfer(`TMW_OFF_CTRL_B, 1'b1, 8'hFF); // Select code 7 keeps the timer stopped.
    xfer(`TMW_OFF_CTRL_B, 1'b0, 8'h00);
    chk("control b", rdv, 32'h0F);
    for (int i = 2; i < 5; i++) begin
      xfer(offs[i], 1'b1, 8'hA5);
      xfer(offs[i], 1'b0, 8'h00);
      chk("data register", rdv, 32'hA5);
    end
    xfer(8'h18, 1'b1, 8'hFF);
    xfer(8'h18, 1'b0, 8'h00);
    chk("unmapped", rdv, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("out a in reset", {28'h0, woa, woa_en, wob, wob_en}, 32'h0);
    hresetn <= 1'b1;
    foreach (offs[i]) begin
      xfer(offs[i], 1'b0, 8'h00);
      chk("reset value", rdv, 32'h0);
      chk("response", {30'h0, hresp, hreadyout}, 32'h1);
    end
    final_report();
  end
  // Cuts a hang short well beyond the roughly 15400 cycles the cases need.
  initial begin
    repeat (40000) @(posedge hclk);
    err_count++;
    final_report();
  end
endmodule : testbench
